// [src/ccf_pkg.sv]
// Purpose: constants and types for the CAN feature configuration block
// Assumes: 32-bit register port, byte addresses, one clock
// Notes:   register offsets and bit positions named once here
// Function
// R01 - filter enable lets buffers share one identifier
// R02 - self-reception disable drops own transmitted frames
// R03 - global warning enable gates warning interrupts
// R04 - tx/rx warning masks, threshold 96
// R05 - warning flags at status bits 14, 15
// R06 - warning flags clear on writing one
// R07 - reset selects oscillator clock for protocol interface
// R08 - writing one selects system clock
// R09 - software switches clock only while halted
// R10 - clock switch applied on oscillator edge
// R11 - filter enable uses per-buffer masks
// R12 - disable in freeze: clock stop, ack bits
// R13 - warning request needs enable, mask, flag
// R14 - flag sets on crossing into threshold only
package ccf_pkg;

  localparam int          NUM_BUF      = 4;
  localparam int          ID_W         = 29;
  localparam int          CNT_W        = 8;
  localparam int          BUF_IDX_W    = 2;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0]  OFF_MODCFG   = 8'h00;
  localparam logic [7:0]  OFF_CTRL     = 8'h04;
  localparam logic [7:0]  OFF_ERRSTAT  = 8'h08;
  localparam logic [7:0]  OFF_BUFSTAT  = 8'h0C;
  localparam logic [7:0]  OFF_GMASK    = 8'h10;
  localparam logic [7:0]  OFF_ID0      = 8'h40;
  localparam logic [7:0]  OFF_BMASK0   = 8'h80;

  // ****************************************
  // bit positions
  // ****************************************
  localparam int          MODCFG_DISABLE     = 31;
  localparam int          MODCFG_HALT        = 28;
  localparam int          MODCFG_FREEZE_ACK  = 24;
  localparam int          MODCFG_LOWPWR_ACK  = 20;
  localparam int          MODCFG_BFE         = 15;
  localparam int          MODCFG_SELF_RX_OFF = 14;
  localparam int          MODCFG_WARN_EN     = 10;
  localparam int          CTRL_RXWMSK        = 21;
  localparam int          CTRL_TXWMSK        = 20;
  localparam int          CTRL_CLKSEL        = 13;
  localparam int          ERRSTAT_RXWFLAG    = 15;
  localparam int          ERRSTAT_TXWFLAG    = 14;
  localparam int          BST_IDX_LSB        = 8;

  // ****************************************
  // reset values and thresholds
  // ****************************************
  localparam logic [CNT_W-1:0] WARN_LEVEL   = 8'h60;
  localparam logic [ID_W-1:0]  GMASK_RST    = 29'h1FFFFFFF;
  localparam logic [ID_W-1:0]  BMASK_RST    = 29'h1FFFFFFF;
  localparam logic             CLKSEL_RST   = 1'b0;

  typedef struct packed {
    logic                           mod_disable;
    logic                           halt;
    logic                           bfe;
    logic                           self_rx_off;
    logic                           warn_en;
    logic                           rx_wmask;
    logic                           tx_wmask;
    logic                           clk_sel_req;
    logic                           clk_sel;
    logic                           tx_wflag;
    logic                           rx_wflag;
    logic                           tx_above;
    logic                           rx_above;
    logic                           lowpwr_ack;
    logic [2:0]                     osc_sync;
    logic [NUM_BUF-1:0]             full;
    logic [NUM_BUF-1:0][ID_W-1:0]   id;
    logic [NUM_BUF-1:0][ID_W-1:0]   bmask;
    logic [ID_W-1:0]                gmask;
    logic [31:0]                    rdata;
    logic                           store_vld;
    logic [BUF_IDX_W-1:0]           store_idx;
    logic [BUF_IDX_W-1:0]           last_idx;
  } ccf_state_t;

  typedef struct packed {
    logic                           valid;
    logic                           self_tx;
    logic [ID_W-1:0]                id;
  } ccf_rx_frame_t;

endpackage : ccf_pkg

// [src/ccf_top.sv]
// Purpose: configuration, filtering and warning logic of a CAN controller
// Assumes: error counters and received frames come from same-clock logic
// Notes:   oscillator clock is sampled as a pin to time the clock switch
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ccf_top (
  input  wire logic                             core_clk_in,
  input  wire logic                             rst_in,
  input  wire logic [7:0]                       addr_in,
  input  wire logic [31:0]                      wdata_in,
  input  wire logic                             wr_in,
  input  wire logic                             rd_in,
  output logic      [31:0]                      rdata_out,
  input  wire logic [ccf_pkg::CNT_W-1:0]        tx_err_cnt_in,
  input  wire logic [ccf_pkg::CNT_W-1:0]        rx_err_cnt_in,
  input  wire ccf_pkg::ccf_rx_frame_t           rx_frame_in,
  input  wire logic                             osc_clk_in,
  output logic                                  store_valid_out,
  output logic      [ccf_pkg::BUF_IDX_W-1:0]    store_buf_out,
  output logic                                  proto_clock_select_out,
  output logic                                  clk_stop_req_out,
  output logic                                  freeze_ack_out,
  output logic                                  low_power_ack_out,
  output logic                                  irq_out
);

  ccf_pkg::ccf_state_t st_ff;
  ccf_pkg::ccf_state_t nxt_st;

  logic                            frozen;
  logic                            tx_now;
  logic                            rx_now;
  logic                            osc_rise;
  logic                            found;
  logic [ccf_pkg::BUF_IDX_W-1:0]   hit_idx;
  logic [ccf_pkg::ID_W-1:0]        eff_mask;
  logic [31:0]                     rd_val;
  logic [31:0]                     w1c;
  logic [7:0]                      idx_addr;

  // ****************************************
  // combinational helpers
  // ****************************************
  // frozen only while halted and not in low power
  assign frozen   = st_ff.halt & ~st_ff.lowpwr_ack;
  assign tx_now   = tx_err_cnt_in >= ccf_pkg::WARN_LEVEL; // R04
  assign rx_now   = rx_err_cnt_in >= ccf_pkg::WARN_LEVEL; // R04
  // only the second and third stages are looked at
  assign osc_rise = st_ff.osc_sync[1] & ~st_ff.osc_sync[2];
  assign w1c      = (wr_in && addr_in == ccf_pkg::OFF_ERRSTAT) ? wdata_in : 32'h0;

  // ****************************************
  // acceptance filter
  // ****************************************
  always_comb begin
    found    = 1'b0;
    hit_idx  = '0;
    eff_mask = '0;
    for (int i = 0; i < ccf_pkg::NUM_BUF; i++) begin
      // per-buffer masks replace the global mask when queuing
      eff_mask = st_ff.bfe ? st_ff.bmask[i] : st_ff.gmask; // R11
      if (!found && (((rx_frame_in.id ^ st_ff.id[i]) & eff_mask) == '0)) begin
        // queuing skips filled buffers, so the next one takes the frame
        if (!st_ff.bfe || !st_ff.full[i]) begin // R01
          found   = 1'b1;
          hit_idx = i[ccf_pkg::BUF_IDX_W-1:0];
        end
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_val   = 32'h0;
    idx_addr = 8'h0;
    case (addr_in)
      ccf_pkg::OFF_MODCFG: begin
        rd_val[ccf_pkg::MODCFG_DISABLE]     = st_ff.mod_disable;
        rd_val[ccf_pkg::MODCFG_HALT]        = st_ff.halt;
        rd_val[ccf_pkg::MODCFG_FREEZE_ACK]  = frozen;
        rd_val[ccf_pkg::MODCFG_LOWPWR_ACK]  = st_ff.lowpwr_ack;
        rd_val[ccf_pkg::MODCFG_BFE]         = st_ff.bfe;
        rd_val[ccf_pkg::MODCFG_SELF_RX_OFF] = st_ff.self_rx_off;
        rd_val[ccf_pkg::MODCFG_WARN_EN]     = st_ff.warn_en;
      end
      ccf_pkg::OFF_CTRL: begin
        rd_val[ccf_pkg::CTRL_RXWMSK] = st_ff.rx_wmask;
        rd_val[ccf_pkg::CTRL_TXWMSK] = st_ff.tx_wmask;
        rd_val[ccf_pkg::CTRL_CLKSEL] = st_ff.clk_sel_req;
      end
      ccf_pkg::OFF_ERRSTAT: begin
        rd_val[ccf_pkg::ERRSTAT_RXWFLAG] = st_ff.rx_wflag; // R05
        rd_val[ccf_pkg::ERRSTAT_TXWFLAG] = st_ff.tx_wflag; // R05
      end
      ccf_pkg::OFF_BUFSTAT: begin
        rd_val[ccf_pkg::NUM_BUF-1:0] = st_ff.full;
        rd_val[ccf_pkg::BST_IDX_LSB +: ccf_pkg::BUF_IDX_W] = st_ff.last_idx;
      end
      ccf_pkg::OFF_GMASK: begin
        rd_val[ccf_pkg::ID_W-1:0] = st_ff.gmask;
      end
      default: begin
        for (int i = 0; i < ccf_pkg::NUM_BUF; i++) begin
          idx_addr = 8'(i * 4);
          if (addr_in == ccf_pkg::OFF_ID0 + idx_addr) begin
            rd_val[ccf_pkg::ID_W-1:0] = st_ff.id[i];
          end
          if (addr_in == ccf_pkg::OFF_BMASK0 + idx_addr) begin
            rd_val[ccf_pkg::ID_W-1:0] = st_ff.bmask[i];
          end
        end
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rdata     = rd_in ? rd_val : 32'h0;
    nxt_st.store_vld = 1'b0;
    nxt_st.osc_sync  = {st_ff.osc_sync[1:0], osc_clk_in};

    // register writes
    if (wr_in) begin
      case (addr_in)
        ccf_pkg::OFF_MODCFG: begin
          nxt_st.mod_disable = wdata_in[ccf_pkg::MODCFG_DISABLE];
          nxt_st.halt        = wdata_in[ccf_pkg::MODCFG_HALT];
          nxt_st.bfe         = wdata_in[ccf_pkg::MODCFG_BFE];
          nxt_st.self_rx_off = wdata_in[ccf_pkg::MODCFG_SELF_RX_OFF];
          nxt_st.warn_en     = wdata_in[ccf_pkg::MODCFG_WARN_EN];
        end
        ccf_pkg::OFF_CTRL: begin
          nxt_st.rx_wmask    = wdata_in[ccf_pkg::CTRL_RXWMSK];
          nxt_st.tx_wmask    = wdata_in[ccf_pkg::CTRL_TXWMSK];
          nxt_st.clk_sel_req = wdata_in[ccf_pkg::CTRL_CLKSEL]; // R08
        end
        ccf_pkg::OFF_BUFSTAT: begin
          // writing one releases a filled buffer
          nxt_st.full = st_ff.full & ~wdata_in[ccf_pkg::NUM_BUF-1:0];
        end
        ccf_pkg::OFF_GMASK: begin
          nxt_st.gmask = wdata_in[ccf_pkg::ID_W-1:0];
        end
        default: begin
          for (int i = 0; i < ccf_pkg::NUM_BUF; i++) begin
            if (addr_in == ccf_pkg::OFF_ID0 + 8'(i * 4)) begin
              nxt_st.id[i] = wdata_in[ccf_pkg::ID_W-1:0];
            end
            if (addr_in == ccf_pkg::OFF_BMASK0 + 8'(i * 4)) begin
              nxt_st.bmask[i] = wdata_in[ccf_pkg::ID_W-1:0];
            end
          end
        end
      endcase
    end

    // software switches only while halted; the device does not enforce it
    // R09
    // new source taken only on an oscillator edge, so halt and select
    // writes in different oscillator periods never meet in one period
    if (osc_rise) begin
      nxt_st.clk_sel = st_ff.clk_sel_req; // R10
    end

    // warning flags: clear by one, set wins over the clear
    nxt_st.tx_above = tx_now;
    nxt_st.rx_above = rx_now;
    if (w1c[ccf_pkg::ERRSTAT_TXWFLAG]) begin
      nxt_st.tx_wflag = 1'b0; // R06
    end
    if (w1c[ccf_pkg::ERRSTAT_RXWFLAG]) begin
      nxt_st.rx_wflag = 1'b0; // R06
    end
    if (tx_now && !st_ff.tx_above) begin
      nxt_st.tx_wflag = 1'b1; // R14
    end
    if (rx_now && !st_ff.rx_above) begin
      nxt_st.rx_wflag = 1'b1; // R14
    end

    // low power entered only from freeze, left when disable drops
    if (st_ff.mod_disable && frozen) begin
      nxt_st.lowpwr_ack = 1'b1; // R12
    end else if (!st_ff.mod_disable) begin
      nxt_st.lowpwr_ack = 1'b0;
    end

    // frame storage; no reception while halted or in low power
    if (rx_frame_in.valid && found && !st_ff.halt && !st_ff.lowpwr_ack) begin
      if (!(st_ff.self_rx_off && rx_frame_in.self_tx)) begin // R02
        nxt_st.full[hit_idx] = 1'b1;
        nxt_st.store_vld     = 1'b1;
        nxt_st.store_idx     = hit_idx;
        nxt_st.last_idx      = hit_idx;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_ff             <= '0;
      st_ff.clk_sel_req <= ccf_pkg::CLKSEL_RST; // R07
      st_ff.clk_sel     <= ccf_pkg::CLKSEL_RST; // R07
      st_ff.gmask       <= ccf_pkg::GMASK_RST;
      st_ff.bmask       <= {ccf_pkg::NUM_BUF{ccf_pkg::BMASK_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_out              = st_ff.rdata;
  assign store_valid_out        = st_ff.store_vld;
  assign store_buf_out          = st_ff.store_idx;
  assign proto_clock_select_out = st_ff.clk_sel; // R08
  assign clk_stop_req_out       = st_ff.lowpwr_ack; // R12
  assign freeze_ack_out         = frozen; // R12
  assign low_power_ack_out      = st_ff.lowpwr_ack; // R12
  // level request, drops as soon as the flag is cleared
  assign irq_out = st_ff.warn_en & ((st_ff.tx_wflag & st_ff.tx_wmask) |
                                  (st_ff.rx_wflag & st_ff.rx_wmask)); // R03 R13

endmodule : ccf_top

`default_nettype wire

// [bench/ccf_can_node.sv]
// Purpose: remote CAN nodes feeding frames and error counts
// Assumes: same clock as the block
// Notes:   released frame lines carry inverted last values
`timescale 1ns/1ps
`default_nettype none
module ccf_can_node (
  input  wire logic                    clk_in,
  output var  ccf_pkg::ccf_rx_frame_t  frame_out,
  output var  logic [7:0]              tx_cnt_out,
  output var  logic [7:0]              rx_cnt_out
);
  initial begin
    frame_out  = '0;
    tx_cnt_out = 8'h00;
    rx_cnt_out = 8'h00;
  end
  task automatic send(input logic [28:0] id, input logic self_tx);
    @(posedge clk_in);
    frame_out <= '{1'b1, self_tx, id};
    @(posedge clk_in);
    // no stale id left on the lines
    frame_out <= '{1'b0, ~self_tx, ~id};
  endtask : send
  task automatic errs(input logic [7:0] tx, input logic [7:0] rx);
    @(posedge clk_in);
    tx_cnt_out <= tx;
    rx_cnt_out <= rx;
  endtask : errs
endmodule : ccf_can_node
`default_nettype wire

// [bench/ccf_top_chk.sv]
// Purpose: port checks of the feature configuration block
// Assumes: one clock, synchronous reset
// Notes:   internal flags are seen through irq_out only
`timescale 1ns/1ps
`default_nettype none
module ccf_top_chk (
  input wire logic                    core_clk_in,
  input wire logic                    rst_in,
  input wire logic [7:0]              addr_in,
  input wire logic [31:0]             wdata_in,
  input wire logic                    wr_in,
  input wire logic                    rd_in,
  input wire logic [31:0]             rdata_out,
  input wire logic [7:0]              tx_err_cnt_in,
  input wire logic [7:0]              rx_err_cnt_in,
  input wire ccf_pkg::ccf_rx_frame_t  rx_frame_in,
  input wire logic                    store_valid_out,
  input wire logic                    proto_clock_select_out,
  input wire logic                    clk_stop_req_out,
  input wire logic                    freeze_ack_out,
  input wire logic                    low_power_ack_out,
  input wire logic                    irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_tx_set;
    $past(tx_err_cnt_in, 2) < 8'h60 && $past(tx_err_cnt_in) >= 8'h60;
  endsequence
  sequence s_rx_set;
    $past(rx_err_cnt_in, 2) < 8'h60 && $past(rx_err_cnt_in) >= 8'h60;
  endsequence
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside its cycle");
  a_store_cause: assert property (store_valid_out |-> $past(rx_frame_in.valid))
    else $error("store without frame");
  a_halt_blocks: assert property ((freeze_ack_out || low_power_ack_out) && rx_frame_in.valid
    |=> !store_valid_out) else $error("frame stored while halted");
  a_irq_cause: assert property ($rose(irq_out) |-> s_tx_set or s_rx_set or $past(wr_in))
    else $error("interrupt without cause");
  a_irq_clear: assert property (irq_out && wr_in && addr_in == ccf_pkg::OFF_ERRSTAT
    && wdata_in[15:14] == 2'b11 && tx_err_cnt_in < 8'h60 && rx_err_cnt_in < 8'h60
    |=> !irq_out) else $error("interrupt kept after clear");
  a_clk_reset: assert property ($fell(rst_in) |-> !proto_clock_select_out)
    else $error("clock select not oscillator after reset");
  a_lp_acks: assert property (low_power_ack_out |-> clk_stop_req_out && !freeze_ack_out)
    else $error("low power acks disagree");
  a_lp_rise: assert property ($rose(low_power_ack_out) |->
    $past(wr_in && addr_in == 8'h00 && wdata_in[31] && wdata_in[28], 2) ||
    $past(wr_in && addr_in == 8'h00 && wdata_in[31] && wdata_in[28])) else $error("lp rise");
  a_lp_fall: assert property ($fell(low_power_ack_out) |->
    $past(wr_in && addr_in == 8'h00, 2) || $past(wr_in && addr_in == 8'h00))
    else $error("lp fall without write");
endmodule : ccf_top_chk
bind ccf_top ccf_top_chk u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .tx_err_cnt_in(tx_err_cnt_in), .rx_err_cnt_in(rx_err_cnt_in),
  .rx_frame_in(rx_frame_in), .store_valid_out(store_valid_out),
  .proto_clock_select_out(proto_clock_select_out), .clk_stop_req_out(clk_stop_req_out),
  .freeze_ack_out(freeze_ack_out), .low_power_ack_out(low_power_ack_out), .irq_out(irq_out));
`default_nettype wire

// [bench/can_ctrl_feature_config_tb.sv]
// Purpose: self-checking bench of the feature configuration block
// Assumes: register port, one read cycle latency
// Notes:   osc at 20 MHz keeps clock ratio below three
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module can_ctrl_feature_config_tb;
  localparam logic [31:0] HALT   = 32'h1 << ccf_pkg::MODCFG_HALT;
  localparam logic [31:0] MODOFF = 32'h1 << ccf_pkg::MODCFG_DISABLE;
  localparam logic [31:0] BFE    = 32'h1 << ccf_pkg::MODCFG_BFE;
  localparam logic [31:0] SRXD   = 32'h1 << ccf_pkg::MODCFG_SELF_RX_OFF;
  localparam logic [31:0] WEN    = 32'h1 << ccf_pkg::MODCFG_WARN_EN;
  localparam logic [31:0] LPA    = 32'h1 << ccf_pkg::MODCFG_LOWPWR_ACK;
  localparam logic [31:0] MSK  = 32'h00300000;
  localparam logic [31:0] CSEL = 32'h1 << ccf_pkg::CTRL_CLKSEL;
  localparam logic [31:0] TXF  = 32'h00004000;
  localparam logic [31:0] RXF  = 32'h00008000;
  typedef struct packed {logic [28:0] id; logic s; logic h; logic [1:0] b;} ccf_row_t;
  localparam ccf_row_t ROWS [6] = '{'{29'h100, 1'b0, 1'b1, 2'h0}, '{29'h100, 1'b0, 1'b1, 2'h1},
    '{29'h100, 1'b0, 1'b0, 2'h0}, '{29'h2AB, 1'b0, 1'b1, 2'h2},
    '{29'h300, 1'b1, 1'b1, 2'h3}, '{29'h555, 1'b0, 1'b0, 2'h0}};
  localparam logic [31:0] IDS [4] = '{32'h100, 32'h100, 32'h200, 32'h300};
  logic clk = 1'b0, osc = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [7:0]  txc, rxc;
  logic [1:0]  sb;
  logic        sv, csel, stp, fak, lak, irq;
  ccf_pkg::ccf_rx_frame_t frm;
  int failures = 0;
  int num_checks = 0;
  initial forever #10 clk = ~clk;
  // phase offset keeps oscillator edges off the core clock edges
  initial begin
    #3;
    forever #25 osc = ~osc;
  end
  ccf_can_node u_node (.clk_in(clk), .frame_out(frm), .tx_cnt_out(txc), .rx_cnt_out(rxc));
  ccf_top DUT (.core_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .tx_err_cnt_in(txc), .rx_err_cnt_in(rxc),
    .rx_frame_in(frm), .osc_clk_in(osc), .store_valid_out(sv), .store_buf_out(sb),
    .proto_clock_select_out(csel), .clk_stop_req_out(stp), .freeze_ack_out(fak),
    .low_power_ack_out(lak), .irq_out(irq));
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : chk_reg
  task automatic chk_frm(input logic [28:0] id, input logic s, input logic h, input logic [1:0] b);
    u_node.send(id, s);
    #1 `CHK(sv, h)
    if (h) `CHK(sb, b)
  endtask : chk_frm
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100us;
    failures++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 `CHK(csel, 1'b0)
    chk_reg(ccf_pkg::OFF_CTRL, 32'h0);
    chk_reg(ccf_pkg::OFF_BMASK0, 32'h1FFFFFFF);
    wr_reg(8'hFC, 32'hFFFFFFFF);
    chk_reg(8'hFC, 32'h0);
    for (int i = 0; i < 4; i++) wr_reg(ccf_pkg::OFF_ID0 + 8'(4 * i), IDS[i]);
    wr_reg(ccf_pkg::OFF_BMASK0 + 8'h08, 32'h1FFFFF00);
    wr_reg(ccf_pkg::OFF_MODCFG, BFE);
    foreach (ROWS[i]) chk_frm(ROWS[i].id, ROWS[i].s, ROWS[i].h, ROWS[i].b);
    $display("test rows done");
    wr_reg(ccf_pkg::OFF_BUFSTAT, 32'hF);
    wr_reg(ccf_pkg::OFF_MODCFG, BFE | SRXD);
    chk_frm(29'h300, 1'b1, 1'b0, 2'h0);
    chk_frm(29'h300, 1'b0, 1'b1, 2'h3);
    wr_reg(ccf_pkg::OFF_MODCFG, 32'h0);
    chk_frm(29'h2AB, 1'b0, 1'b0, 2'h0);
    chk_frm(29'h100, 1'b0, 1'b1, 2'h0);
    $display("test filter done");
    wr_reg(ccf_pkg::OFF_MODCFG, HALT | MODOFF);
    @(posedge clk);
    #1 `CHK({lak, stp, fak}, 3'b110)
    chk_reg(ccf_pkg::OFF_MODCFG, HALT | MODOFF | LPA);
    chk_frm(29'h100, 1'b0, 1'b0, 2'h0);
    wr_reg(ccf_pkg::OFF_MODCFG, HALT);
    wr_reg(ccf_pkg::OFF_CTRL, CSEL);
    // select is looked at after it settles, not in its launch step
    for (int k = 0; k < 12 && csel !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK({csel, lak, fak}, 3'b101)
    chk_reg(ccf_pkg::OFF_CTRL, CSEL);
    $display("test halt done");
    wr_reg(ccf_pkg::OFF_CTRL, CSEL | MSK);
    wr_reg(ccf_pkg::OFF_MODCFG, WEN);
    u_node.errs(8'd95, 8'd0);
    u_node.errs(8'd96, 8'd0);
    @(posedge clk);
    #1 `CHK(irq, 1'b1)
    chk_reg(ccf_pkg::OFF_ERRSTAT, TXF);
    wr_reg(ccf_pkg::OFF_ERRSTAT, 32'h0);
    chk_reg(ccf_pkg::OFF_ERRSTAT, TXF);
    wr_reg(ccf_pkg::OFF_ERRSTAT, TXF);
    `CHK(irq, 1'b0)
    u_node.errs(8'd100, 8'd96);
    chk_reg(ccf_pkg::OFF_ERRSTAT, RXF);
    wr_reg(ccf_pkg::OFF_CTRL, CSEL);
    `CHK(irq, 1'b0)
    wr_reg(ccf_pkg::OFF_CTRL, CSEL | MSK);
    wr_reg(ccf_pkg::OFF_MODCFG, 32'h0);
    `CHK(irq, 1'b0)
    wr_reg(ccf_pkg::OFF_MODCFG, WEN);
    u_node.errs(8'd0, 8'd96);
    u_node.errs(8'd96, 8'd0);
    chk_reg(ccf_pkg::OFF_ERRSTAT, TXF | RXF);
    `CHK(irq, 1'b1)
    // counters back below the level so the clear cannot race a new set
    u_node.errs(8'd0, 8'd0);
    wr_reg(ccf_pkg::OFF_ERRSTAT, TXF | RXF);
    `CHK(irq, 1'b0)
    $display("test warnings done");
    complete_run();
  end
endmodule : can_ctrl_feature_config_tb
`default_nettype wire
